//--- hw/udl_consts.svh
`ifndef UDL_CONSTS_SVH
`define UDL_CONSTS_SVH
// Register indices, byte address is index times four
`define UDL_IDX_CTL      6'h00
`define UDL_IDX_WAKE     6'h02
`define UDL_IDX_TGL      6'h04
`define UDL_IDX_ADDR     6'h08
`define UDL_IDX_ISO      6'h0a
`define UDL_IDX_FLAG     6'h10
// Field positions
`define UDL_CTL_OSC_EN   15
`define UDL_CTL_ICLK_EN  11
`define UDL_CTL_XOC_HI   9
`define UDL_CTL_XOC_LO   8
`define UDL_CTL_OP_EN    0
`define UDL_CTL_WMASK    16'hff01
`define UDL_WAKE_REQ     0
`define UDL_ISO_LATCH    11
`define UDL_FLAG_FRAME   0
// Encodings
`define UDL_XOC_FLOAT    2'h0
`define UDL_XOC_LOW      2'h1
`define UDL_XOC_RSVD     2'h2
`define UDL_XOC_HIGH     2'h3
`define UDL_DS_DEFAULT   3'h1
`define UDL_DS_SUSP      2
`define UDL_TYPE_ISO     2'h3
// Reset values
`define UDL_RST_WORD     16'h0000
// Timing
`define UDL_CNT_W        17
`define UDL_CLK_KHZ      10000
`define UDL_IDLE_MS      2
`define UDL_K_MS         10
`endif

//--- hw/udl_pkg.sv
`include "udl_consts.svh"
package udl_pkg;
	typedef enum logic [2:0] {
		UDL_W_IDLE  = 3'b001,
		UDL_W_WAIT  = 3'b010,
		UDL_W_DRIVE = 3'b100
	} udl_wphase_t;
	typedef struct packed {
		udl_wphase_t                 phase;
		logic [`UDL_CNT_W-1:0]       idle_cnt;
		logic [`UDL_CNT_W-1:0]       k_cnt;
	} udl_wake_t;
	typedef struct packed {
		logic [7:0]                  addr;
		logic [15:0]                 wdata;
		logic                        wr;
		logic                        rd;
	} udl_bus_t;
	typedef struct packed {
		logic [2:0]                  device_state_field;
		logic                        bus_reset;
		logic                        sof_ok;
		logic [10:0]                 sof_frame;
		logic                        iso_done;
		logic [2:0]                  iso_ep;
		logic [6:0]                  ep_ack;
		logic                        setaddr_req;
		logic [6:0]                  setaddr;
		logic                        zlp_sent;
	} udl_usb_ev_t;
	typedef struct packed {
		logic [15:0]                 ctl;
		logic [6:0]                  addr;
		logic [6:0]                  pend_addr;
		logic                        pend_valid;
		logic                        frame_latch_mode;
		logic [10:0]                 frame_number_field;
		logic [10:0]                 last_sof;
		logic                        frame_received_flag;
		logic [6:0]                  toggle;
		logic [15:0]                 rdata;
		logic                        pin_out;
		logic                        pin_oe_n;
		logic                        engine_en;
	} udl_state_t;
endpackage

//--- hw/udl_wake_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "udl_consts.svh"
module udl_wake_seq #(
	parameter int unsigned IDLE_CYC = 20000,
	parameter int unsigned K_CYC    = 100000
) (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// Control
	input  wire logic srst_i,
	input  wire logic clk_run_i,
	input  wire logic suspended_i,
	input  wire logic req_i,
	// Status
	output logic      pending_o,
	output logic      k_drive_o
);
	localparam logic [`UDL_CNT_W-1:0] IDLE_END = `UDL_CNT_W'(IDLE_CYC);
	localparam logic [`UDL_CNT_W-1:0] K_END    = `UDL_CNT_W'(K_CYC - 1);

	udl_pkg::udl_wake_t s;
	udl_pkg::udl_wake_t d;
	logic               idle_done;

	assign idle_done = s.idle_cnt == IDLE_END;
	assign pending_o = s.phase != udl_pkg::UDL_W_IDLE;
	assign k_drive_o = s.phase == udl_pkg::UDL_W_DRIVE;

	// ****************************************
	// Wakeup sequencing
	// ****************************************
	always_comb begin
		d = s;
		if (!suspended_i) begin
			d.idle_cnt = '0;
		end else if (clk_run_i && !idle_done) begin
			d.idle_cnt = s.idle_cnt + 1'b1;
		end
		unique case (s.phase)
			udl_pkg::UDL_W_IDLE: begin
				if (req_i) begin
					d.phase = udl_pkg::UDL_W_WAIT;
				end
			end
			udl_pkg::UDL_W_WAIT: begin
				if (!suspended_i) begin
					d.phase = udl_pkg::UDL_W_IDLE;
				end else if (idle_done) begin
					d.phase = udl_pkg::UDL_W_DRIVE;
					d.k_cnt = '0;
				end
			end
			udl_pkg::UDL_W_DRIVE: begin
				if (clk_run_i) begin
					if (s.k_cnt == K_END) begin
						d.phase = udl_pkg::UDL_W_IDLE;
					end else begin
						d.k_cnt = s.k_cnt + 1'b1;
					end
				end
			end
		endcase
		if (srst_i) begin
			d.phase    = udl_pkg::UDL_W_IDLE;
			d.idle_cnt = '0;
			d.k_cnt    = '0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '{phase: udl_pkg::UDL_W_IDLE, default: '0};
		end else begin
			s <= d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_idle_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(k_drive_o) |-> $past(idle_done) && $past(suspended_i))
		else $error("K state began before idle time");
	chk_k_pause: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		k_drive_o && !clk_run_i && !srst_i |=> $stable(s.k_cnt) && k_drive_o)
		else $error("K count moved without clock");
	chk_idle_pause: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		suspended_i && !clk_run_i && !srst_i ##1 suspended_i && !srst_i |-> $stable(s.idle_cnt))
		else $error("Idle count moved without clock");
endmodule
`default_nettype wire

//--- hw/udl_link_ctrl.sv
// Function
// - Output control drives pin and serial engine
// - Codes: 00 float/stop, 01 low, 11 high
// - Operation enable low holds software reset
// - Wakeup request accepted only while suspended
// - Accepted wakeup drives K 10 ms, self-clears
// - Wakeup bit reads pending; writing 0 ignored
// - Early request waits 2 ms after suspend
// - Wakeup counts pause while clocks disabled
// - Toggle clear bit forces endpoint DATA0
// - Toggle clear bits always read zero
// - Hardware toggles on each successful transaction
// - Bus and software resets never change endpoint data toggles
// - Device address is read-only to software
// - Set-address in default state loads address
// - Address latched at zero-length status packet
// - Frame status valid only for isochronous endpoints
// - Latch mode 0 captures each good frame
// - Latch mode 1 captures at isochronous completion
// - Frame number read-only; capture sets flag
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "udl_consts.svh"
module udl_link_ctrl #(
	parameter int unsigned IDLE_CYC = `UDL_IDLE_MS * `UDL_CLK_KHZ,
	parameter int unsigned K_CYC    = `UDL_K_MS * `UDL_CLK_KHZ
) (
	// Clock and reset
	input  wire logic                mclk_i,
	input  wire logic                rst_n_i,
	// Register port
	input  wire udl_pkg::udl_bus_t   bus_i,
	output logic [15:0]              rdata_o,
	// USB engine events
	input  wire udl_pkg::udl_usb_ev_t usb_ev_i,
	input  wire logic [13:0]         endpoint_transfer_type_i,
	// Transceiver and link
	output logic                     transceiver_on_pin_o,
	output logic                     transceiver_on_pin_oe_n_o,
	output logic                     serial_interface_engine_en_o,
	output logic                     k_state_drive_o,
	// Endpoint and frame state
	output logic [6:0]               data_toggle_o,
	output logic [6:0]               device_address_o,
	output logic [10:0]              frame_number_field_o,
	output logic                     frame_received_flag_o
);
	udl_pkg::udl_state_t q;
	udl_pkg::udl_state_t d;
	logic                wr_ctl;
	logic                wr_wake;
	logic                wr_tgl;
	logic                wr_iso;
	logic                wr_flag;
	logic                wake_req;
	logic                wake_pending;
	logic                clk_run;
	logic [6:0]          tgl_nxt;
	logic [7:0]          iso_vec;
	logic                frame_set;
	logic                op_en_nxt;

	// ****************************************
	// Address decode
	// ****************************************
	assign wr_ctl  = bus_i.wr && bus_i.addr == {`UDL_IDX_CTL, 2'b00};
	assign wr_wake = bus_i.wr && bus_i.addr == {`UDL_IDX_WAKE, 2'b00};
	assign wr_tgl  = bus_i.wr && bus_i.addr == {`UDL_IDX_TGL, 2'b00};
	assign wr_iso  = bus_i.wr && bus_i.addr == {`UDL_IDX_ISO, 2'b00};
	assign wr_flag = bus_i.wr && bus_i.addr == {`UDL_IDX_FLAG, 2'b00};

	assign clk_run  = q.ctl[`UDL_CTL_OSC_EN] && q.ctl[`UDL_CTL_ICLK_EN];
	assign wake_req = wr_wake && bus_i.wdata[`UDL_WAKE_REQ]
		&& usb_ev_i.device_state_field[`UDL_DS_SUSP] && q.ctl[`UDL_CTL_OP_EN];
	assign op_en_nxt = d.ctl[`UDL_CTL_OP_EN];

	// ****************************************
	// Per-endpoint toggle and type
	// ****************************************
	assign iso_vec[7] = 1'b0;
	for (genvar i = 0; i < 7; i++) begin : g_ep
		assign iso_vec[i] = endpoint_transfer_type_i[2*i+1 -: 2] == `UDL_TYPE_ISO;
		assign tgl_nxt[i] = (wr_tgl && bus_i.wdata[i]) ? 1'b0
			: q.toggle[i] ^ usb_ev_i.ep_ack[i];
	end

	// ****************************************
	// Remote wakeup sequencer
	// ****************************************
	udl_wake_seq #(
		.IDLE_CYC (IDLE_CYC),
		.K_CYC    (K_CYC)
	) u_wake (
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.srst_i      (!op_en_nxt),
		.clk_run_i   (clk_run),
		.suspended_i (usb_ev_i.device_state_field[`UDL_DS_SUSP]),
		.req_i       (wake_req),
		.pending_o   (wake_pending),
		.k_drive_o   (k_state_drive_o)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		frame_set = 1'b0;
		d.rdata = `UDL_RST_WORD;
		if (wr_ctl) begin
			d.ctl = bus_i.wdata & `UDL_CTL_WMASK;
		end
		unique case (d.ctl[`UDL_CTL_XOC_HI:`UDL_CTL_XOC_LO])
			`UDL_XOC_FLOAT: begin
				d.pin_out   = 1'b0;
				d.pin_oe_n  = 1'b1;
				d.engine_en = 1'b0;
			end
			`UDL_XOC_LOW: begin
				d.pin_out   = 1'b0;
				d.pin_oe_n  = 1'b0;
				d.engine_en = 1'b1;
			end
			`UDL_XOC_RSVD: begin
				d.pin_out   = 1'b0;
				d.pin_oe_n  = 1'b1;
				d.engine_en = 1'b0;
			end
			`UDL_XOC_HIGH: begin
				d.pin_out   = 1'b1;
				d.pin_oe_n  = 1'b0;
				d.engine_en = 1'b1;
			end
		endcase

		// Toggles, untouched by either reset
		d.toggle = tgl_nxt;

		// Address capture
		if (usb_ev_i.setaddr_req && usb_ev_i.device_state_field == `UDL_DS_DEFAULT) begin
			d.pend_addr  = usb_ev_i.setaddr;
			d.pend_valid = 1'b1;
		end
		if (usb_ev_i.zlp_sent && q.pend_valid) begin
			d.addr       = q.pend_addr;
			d.pend_valid = 1'b0;
		end
		if (usb_ev_i.bus_reset) begin
			d.addr       = '0;
			d.pend_valid = 1'b0;
		end

		// Frame number capture
		if (usb_ev_i.sof_ok) begin
			d.last_sof = usb_ev_i.sof_frame;
		end
		if (wr_iso) begin
			d.frame_latch_mode = bus_i.wdata[`UDL_ISO_LATCH];
		end
		if (wr_flag && bus_i.wdata[`UDL_FLAG_FRAME]) begin
			d.frame_received_flag = 1'b0;
		end
		if (!q.frame_latch_mode && usb_ev_i.sof_ok) begin
			d.frame_number_field = usb_ev_i.sof_frame;
			frame_set = 1'b1;
		end else if (q.frame_latch_mode && usb_ev_i.iso_done && iso_vec[usb_ev_i.iso_ep]) begin
			d.frame_number_field = q.last_sof;
			frame_set = 1'b1;
		end
		if (frame_set) begin
			d.frame_received_flag = 1'b1;
		end

		// Software reset state
		if (!d.ctl[`UDL_CTL_OP_EN]) begin
			d.addr                = '0;
			d.pend_addr           = '0;
			d.pend_valid          = 1'b0;
			d.frame_latch_mode    = 1'b0;
			d.frame_number_field  = '0;
			d.last_sof            = '0;
			d.frame_received_flag = 1'b0;
		end

		// Read data, one cycle after the strobe
		if (bus_i.rd) begin
			case (bus_i.addr)
				{`UDL_IDX_CTL, 2'b00}: begin
					d.rdata = q.ctl;
				end
				{`UDL_IDX_WAKE, 2'b00}: begin
					d.rdata = {15'h0000, wake_pending};
				end
				{`UDL_IDX_ADDR, 2'b00}: begin
					d.rdata = {9'h000, q.addr};
				end
				{`UDL_IDX_ISO, 2'b00}: begin
					d.rdata = {4'h0, q.frame_latch_mode, q.frame_number_field};
				end
				{`UDL_IDX_FLAG, 2'b00}: begin
					d.rdata = {15'h0000, q.frame_received_flag};
				end
				default: begin
					d.rdata = `UDL_RST_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q          <= '0;
			q.pin_oe_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rdata_o                      = q.rdata;
	assign transceiver_on_pin_o         = q.pin_out;
	assign transceiver_on_pin_oe_n_o    = q.pin_oe_n;
	assign serial_interface_engine_en_o = q.engine_en;
	assign data_toggle_o                = q.toggle;
	assign device_address_o             = q.addr;
	assign frame_number_field_o         = q.frame_number_field;
	assign frame_received_flag_o        = q.frame_received_flag;

	// ****************************************
	// Checks
	// ****************************************
	int unsigned k_run;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			k_run <= 0;
		end else if (!k_state_drive_o) begin
			k_run <= 0;
		end else if (clk_run) begin
			k_run <= k_run + 1;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_ctl_wr(logic [1:0] code);
		wr_ctl && bus_i.wdata[`UDL_CTL_XOC_HI:`UDL_CTL_XOC_LO] == code;
	endsequence

	chk_pin_drive: assert property (s_ctl_wr(`UDL_XOC_LOW) |=>
		!transceiver_on_pin_oe_n_o && !transceiver_on_pin_o && serial_interface_engine_en_o)
		else $error("Pin not driven low with engine on");
	chk_pin_float: assert property (s_ctl_wr(`UDL_XOC_FLOAT) |=>
		transceiver_on_pin_oe_n_o && !serial_interface_engine_en_o)
		else $error("Pin not floated with engine stopped");
	chk_srst_hold: assert property (!q.ctl[`UDL_CTL_OP_EN] |->
		q.addr == 7'h00 && q.frame_number_field == 11'h000 && !frame_received_flag_o && !wake_pending)
		else $error("Register left software reset value");
	chk_wake_reject: assert property (wr_wake && !wake_req && !wake_pending |=> !wake_pending)
		else $error("Wakeup accepted outside suspend");
	chk_wake_accept: assert property (wake_req && !wake_pending ##1 q.ctl[`UDL_CTL_OP_EN] |-> wake_pending)
		else $error("Wakeup request not taken");
	chk_k_length: assert property ($fell(k_state_drive_o) && q.ctl[`UDL_CTL_OP_EN] |->
		$past(k_run) == K_CYC - 1 && !wake_pending)
		else $error("K state length wrong");
	chk_wake_read: assert property (bus_i.rd && bus_i.addr == {`UDL_IDX_WAKE, 2'b00} |=>
		rdata_o == {15'h0000, $past(wake_pending)})
		else $error("Wakeup bit read wrong");
	chk_tgl_clear: assert property (wr_tgl |=> (data_toggle_o & $past(bus_i.wdata[6:0])) == 7'h00)
		else $error("Toggle not cleared");
	chk_tgl_flip: assert property (1'b1 |=>
		(data_toggle_o ^ $past(data_toggle_o)) == ($past(usb_ev_i.ep_ack) & ~$past(wr_tgl ? bus_i.wdata[6:0] : 7'h00))
		|| $past(wr_tgl))
		else $error("Toggle changed without transaction");
	chk_addr_load: assert property (usb_ev_i.zlp_sent && q.pend_valid && !usb_ev_i.bus_reset
		##1 q.ctl[`UDL_CTL_OP_EN] |-> device_address_o == $past(q.pend_addr))
		else $error("Address not latched at status packet");
	chk_addr_ro: assert property (!(usb_ev_i.zlp_sent && q.pend_valid) && !usb_ev_i.bus_reset
		##1 q.ctl[`UDL_CTL_OP_EN] |-> $stable(device_address_o))
		else $error("Address changed without status packet");
	chk_frame_sof: assert property (!q.frame_latch_mode && usb_ev_i.sof_ok ##1 q.ctl[`UDL_CTL_OP_EN] |->
		frame_number_field_o == $past(usb_ev_i.sof_frame) && frame_received_flag_o)
		else $error("Frame not captured at start of frame");
	chk_frame_iso: assert property (q.frame_latch_mode && usb_ev_i.iso_done
		##1 q.ctl[`UDL_CTL_OP_EN] |-> frame_number_field_o ==
		($past(iso_vec[usb_ev_i.iso_ep]) ? $past(q.last_sof) : $past(frame_number_field_o)))
		else $error("Frame capture at transfer end wrong");
	chk_frame_hold: assert property (!usb_ev_i.sof_ok && !usb_ev_i.iso_done
		##1 q.ctl[`UDL_CTL_OP_EN] |-> $stable(frame_number_field_o))
		else $error("Frame number changed between captures");

	// ****************************************
	// Read-back and reset checks
	// ****************************************
	sequence s_rd(logic [7:0] a);
		bus_i.rd && bus_i.addr == a;
	endsequence

	chk_pin_high: assert property (s_ctl_wr(`UDL_XOC_HIGH) |=>
		!transceiver_on_pin_oe_n_o && transceiver_on_pin_o && serial_interface_engine_en_o)
		else $error("Pin not driven high with engine on");
	chk_pin_rsvd: assert property (s_ctl_wr(`UDL_XOC_RSVD) |=>
		transceiver_on_pin_oe_n_o && !serial_interface_engine_en_o)
		else $error("Reserved code left pin driven");
	chk_tgl_read: assert property (s_rd({`UDL_IDX_TGL, 2'b00}) |=>
		rdata_o == 16'h0000)
		else $error("Toggle clear bits read nonzero");
	chk_addr_read: assert property (s_rd({`UDL_IDX_ADDR, 2'b00}) |=>
		rdata_o == {9'h000, $past(device_address_o)})
		else $error("Address read wrong");
	chk_iso_read: assert property (s_rd({`UDL_IDX_ISO, 2'b00}) |=>
		rdata_o == {4'h0, $past(q.frame_latch_mode), $past(frame_number_field_o)})
		else $error("Frame status read wrong");
	chk_flag_read: assert property (s_rd({`UDL_IDX_FLAG, 2'b00}) |=>
		rdata_o == {15'h0000, $past(frame_received_flag_o)})
		else $error("Frame flag read wrong");
	chk_tgl_busrst: assert property (usb_ev_i.bus_reset && !wr_tgl && usb_ev_i.ep_ack == 7'h00 |=>
		$stable(data_toggle_o))
		else $error("Bus reset changed a toggle");
	chk_tgl_srst: assert property (!op_en_nxt && !wr_tgl && usb_ev_i.ep_ack == 7'h00 |=>
		$stable(data_toggle_o))
		else $error("Software reset changed a toggle");
	chk_addr_busrst: assert property (usb_ev_i.bus_reset |=>
		device_address_o == 7'h00)
		else $error("Bus reset left address set");
	chk_addr_pend: assert property (usb_ev_i.setaddr_req && !usb_ev_i.bus_reset
		&& usb_ev_i.device_state_field == `UDL_DS_DEFAULT && !usb_ev_i.zlp_sent && op_en_nxt |=>
		q.pend_valid && q.pend_addr == $past(usb_ev_i.setaddr))
		else $error("Requested address not held");
	chk_flag_set: assert property (frame_set && op_en_nxt |=>
		frame_received_flag_o)
		else $error("Frame flag not set on capture");
	chk_flag_clear: assert property (wr_flag && bus_i.wdata[`UDL_FLAG_FRAME] && !frame_set |=>
		!frame_received_flag_o)
		else $error("Frame flag not cleared");
	chk_latch_wr: assert property (wr_iso && op_en_nxt |=>
		q.frame_latch_mode == $past(bus_i.wdata[`UDL_ISO_LATCH]))
		else $error("Latch mode not stored");
endmodule
`default_nettype wire

//--- bench/udl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module udl_host_model (
	// Clock
	input  wire logic            mclk_i,
	// Bus events toward the device
	output udl_pkg::udl_usb_ev_t usb_ev_o,
	output logic [13:0]          endpoint_transfer_type_o
);
	// ****************************************
	// Idle levels and event pulses
	// ****************************************
	initial begin
		usb_ev_o = '0;
		usb_ev_o.iso_ep = 3'h7;
		endpoint_transfer_type_o = 14'h0000;
	end

	// Device state and endpoint types
	task automatic set_lvl(input logic [2:0] ds, input logic [13:0] ty);
		@(posedge mclk_i);
		usb_ev_o.device_state_field <= ds;
		endpoint_transfer_type_o    <= ty;
		#1;
	endtask

	// Kinds: 0 sof, 1 ack, 2 set address, 3 status zlp, 4 bus reset, 5 iso done
	task automatic send(input int k, input logic [10:0] v);
		@(posedge mclk_i);
		case (k)
			0: begin
				usb_ev_o.sof_ok    <= 1'b1;
				usb_ev_o.sof_frame <= v;
			end
			1: usb_ev_o.ep_ack <= v[6:0];
			2: begin
				usb_ev_o.setaddr_req <= 1'b1;
				usb_ev_o.setaddr     <= v[6:0];
			end
			3: usb_ev_o.zlp_sent <= 1'b1;
			4: usb_ev_o.bus_reset <= 1'b1;
			default: begin
				usb_ev_o.iso_done <= 1'b1;
				usb_ev_o.iso_ep   <= v[2:0];
			end
		endcase
		@(posedge mclk_i);
		usb_ev_o.sof_ok      <= 1'b0;
		usb_ev_o.ep_ack      <= 7'h00;
		usb_ev_o.setaddr_req <= 1'b0;
		usb_ev_o.zlp_sent    <= 1'b0;
		usb_ev_o.bus_reset   <= 1'b0;
		usb_ev_o.iso_done    <= 1'b0;
		// Stale payload inverted so it never looks valid
		usb_ev_o.sof_frame   <= ~v;
		usb_ev_o.setaddr     <= ~v[6:0];
		usb_ev_o.iso_ep      <= 3'h7;
		#1;
	endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "udl_consts.svh"
module tb_top;
	typedef struct packed {
		logic [15:0] w;
		logic        oe_n;
		logic        eng;
		logic        pin;
	} udl_row_t;
	logic                 mclk_i;
	logic                 rst_n_i;
	udl_pkg::udl_bus_t    bus;
	udl_pkg::udl_usb_ev_t ev;
	logic [13:0]          ty;
	logic [15:0]          rdata;
	logic                 pin, oe_n, eng, k, flag;
	logic [6:0]           tgl, addr;
	logic [10:0]          frm;
	int                   n_mismatch, cmp_count, cyc, k_len, t0;
	udl_row_t             rows [6] = '{{16'h0001, 1'b1, 1'b0, 1'b0}, {16'h0101, 1'b0, 1'b1, 1'b0},
		{16'h0301, 1'b0, 1'b1, 1'b1}, {16'h0201, 1'b1, 1'b0, 1'b0}, {16'h74ff, 1'b1, 1'b0, 1'b0},
		{16'h0300, 1'b0, 1'b1, 1'b1}};
	logic [7:0]           regs [6] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h28, 8'h40};

	udl_link_ctrl #(.IDLE_CYC(8), .K_CYC(16)) i_udl_link_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus),
		.rdata_o(rdata), .usb_ev_i(ev), .endpoint_transfer_type_i(ty), .transceiver_on_pin_o(pin),
		.transceiver_on_pin_oe_n_o(oe_n), .serial_interface_engine_en_o(eng), .k_state_drive_o(k),
		.data_toggle_o(tgl), .device_address_o(addr), .frame_number_field_o(frm), .frame_received_flag_o(flag));
	udl_host_model u_host (.mclk_i(mclk_i), .usb_ev_o(ev), .endpoint_transfer_type_o(ty));

	// ****************************************
	// Clock, counters and tasks
	// ****************************************
	initial mclk_i = 1'b0;
	always #50 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc++;
		if (k === 1'b1) k_len++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus.wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk_i);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic wait_k(input logic lvl);
		int n;
		n = 0;
		while (k !== lvl && n < 60) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
	endtask
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#(100 * 4000);
		n_mismatch++;
		conclude();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		bus = '0;
		rst_n_i = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		cyc = 0;
		k_len = 0;
		repeat (12) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		#1;
		chk({oe_n, eng, k, tgl, addr, frm, flag}, 32'h10000000);
		foreach (regs[i]) rdc(regs[i], 16'h0000);
		foreach (rows[i]) begin
			wr(8'h00, rows[i].w);
			chk({oe_n, eng}, {rows[i].oe_n, rows[i].eng});
			if (!rows[i].oe_n) chk(pin, rows[i].pin);
			rdc(8'h00, rows[i].w & `UDL_CTL_WMASK);
		end
		// Data toggles
		wr(8'h00, 16'h8b01);
		u_host.send(1, 11'h07f);
		u_host.send(1, 11'h005);
		chk(tgl, 7'h7a);
		wr(8'h10, 16'h0042); // Endpoints 1 and 6 forced to DATA0
		chk(tgl, 7'h38);
		rdc(8'h10, 16'h0000);
		u_host.send(1, 11'h002);
		chk(tgl, 7'h3a);
		wr(8'h00, 16'h8b00);
		chk(tgl, 7'h3a);
		u_host.send(4, 11'h000);
		chk(tgl, 7'h3a);
		wr(8'h00, 16'h8b01);
		// Device address
		u_host.set_lvl(3'h1, 14'h000c);
		wr(8'h20, 16'h007f);
		rdc(8'h20, 16'h0000);
		u_host.send(2, 11'h02a);
		chk(addr, 7'h00);
		u_host.send(3, 11'h000);
		chk(addr, 7'h2a);
		rdc(8'h20, 16'h002a);
		u_host.send(4, 11'h000);
		u_host.set_lvl(3'h2, 14'h000c);
		u_host.send(2, 11'h011);
		u_host.send(3, 11'h000);
		chk(addr, 7'h00);
		// Frame number capture
		u_host.send(0, 11'h5a5);
		chk({frm, flag}, {11'h5a5, 1'b1});
		wr(8'h40, 16'h0001);
		chk(flag, 1'b0);
		wr(8'h28, 16'hffff);
		rdc(8'h28, 16'h0da5);
		u_host.send(0, 11'h123);
		chk({frm, flag}, {11'h5a5, 1'b0});
		u_host.send(5, 11'h002);
		chk({frm, flag}, {11'h5a5, 1'b0});
		u_host.send(5, 11'h001);
		chk({frm, flag}, {11'h123, 1'b1});
		rdc(8'h40, 16'h0001);
		wr(8'h00, 16'h8b00);
		chk({frm, flag}, 12'h000);
		rdc(8'h28, 16'h0000);
		wr(8'h00, 16'h8b01);
		// Remote wakeup
		wr(8'h08, 16'h0001);
		rdc(8'h08, 16'h0000);
		u_host.set_lvl(3'h4, 14'h000c);
		t0 = cyc;
		wr(8'h08, 16'h0001);
		wr(8'h08, 16'h0000);
		rdc(8'h08, 16'h0001);
		chk(k, 1'b0);
		k_len = 0;
		wait_k(1'b1);
		chk((cyc - t0 >= 8) && (cyc - t0 <= 14), 1'b1);
		wait_k(1'b0);
		chk(k_len, 16);
		rdc(8'h08, 16'h0000);
		k_len = 0;
		wr(8'h08, 16'h0001);
		wait_k(1'b1);
		wr(8'h00, 16'h8301);
		repeat (10) @(posedge mclk_i);
		#1;
		chk(k, 1'b1);
		wr(8'h00, 16'h8b01);
		wait_k(1'b0);
		chk(k_len >= 26, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
